// File: rtl/dma_sequencer.sv
// Four-channel transfer sequencer with programming port and transfer timing
`timescale 1ns/1ns
module dma_sequencer (
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic [3:0]  channel_request,
	input  wire logic        hold_grant,
	input  wire logic        ready,
	input  wire logic        cs_n,
	input  wire logic [3:0]  register_select_lines,
	input  wire logic        io_read_strobe_n_in,
	output logic             io_read_strobe_n_out,
	output logic             io_read_strobe_oe,
	input  wire logic        io_write_strobe_n_in,
	output logic             io_write_strobe_n_out,
	output logic             io_write_strobe_oe,
	input  wire logic [7:0]  data_in,
	output logic      [7:0]  data_out,
	output logic             data_oe,
	input  wire logic        end_of_service_n_in,
	output logic             end_of_service_n_out,
	output logic             end_of_service_oe,
	output logic             bus_hold_request,
	output logic      [3:0]  channel_grant,
	output logic      [15:0] address_out,
	output logic             address_oe,
	output logic             memory_read_strobe_n,
	output logic             memory_write_strobe_n,
	output logic             terminal_count
);
	typedef struct packed {
		dma_seq_pkg::pins_t                s1;
		dma_seq_pkg::pins_t                s2;
		logic                              iow_prev;
		logic                              ior_prev;
		dma_seq_pkg::fsm_t                 fsm;
		logic [1:0]                        ch;
		logic                              m2m;
		logic                              cascade;
		dma_seq_pkg::chan_t [3:0]          chan;
		dma_seq_pkg::mode_t [3:0]          mode;
		logic [7:0]                        command;
		logic [3:0]                        mask;
		logic [3:0]                        sw_req;
		logic [3:0]                        tc_stat;
		logic                              ptr;
		logic [7:0]                        temp;
		logic [7:0]                        dout;
		logic                              dout_oe;
		logic                              hold;
		logic                              tc_out;
	} st_t;

	st_t              st;
	st_t              next_st;
	logic [1:0]       rst_q;
	logic             rst_n_sync;
	logic [3:0]       valid_req;
	logic [3:0]       pick_grant;
	logic [1:0]       pick_index;
	logic             pick_any;
	logic             buf_in_valid;
	logic             buf_in_ready;
	logic             buf_out_valid;
	logic             buf_out_ready;
	logic [7:0]       buf_out_data;
	logic             prog;
	logic             wr_edge;
	logic             rd_edge;
	logic             working;
	logic             active;
	logic [1:0]       xf;
	logic [1:0]       addr_ch;

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			rst_q <= 2'h0;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_n_sync = rst_q[1];

	// Disable command blocks every request
	assign valid_req = st.command[dma_seq_pkg::CMD_DISABLE] ? 4'h0 :
		((st.s2.req & ~st.mask) | st.sw_req);

	fixed_priority #(.N(dma_seq_pkg::NCH)) u_pick (
		.req   (valid_req),
		.grant (pick_grant),
		.index (pick_index),
		.any   (pick_any)
	);

	two_entry_buffer #(.WIDTH(8)) u_buf (
		.mclk      (mclk),
		.rst_n     (rst_n_sync),
		.in_valid  (buf_in_valid),
		.in_ready  (buf_in_ready),
		.in_data   (st.s2.data),
		.out_valid (buf_out_valid),
		.out_ready (buf_out_ready),
		.out_data  (buf_out_data)
	);

	assign buf_in_valid  = (st.fsm == dma_seq_pkg::ST_M14);
	assign buf_out_ready = (st.fsm == dma_seq_pkg::ST_M24);

	// Programming condition
	assign prog    = !st.s2.cs_n && !st.s2.grant_in &&
		(st.fsm == dma_seq_pkg::ST_IDLE || st.fsm == dma_seq_pkg::ST_HOLD);
	assign wr_edge = prog && !st.s2.iow_n && st.iow_prev;
	assign rd_edge = prog && !st.s2.ior_n && st.ior_prev;

	// Advance one channel by a transfer
	function automatic dma_seq_pkg::chan_t advance(dma_seq_pkg::chan_t c,
		dma_seq_pkg::mode_t m, logic keep_addr);
		dma_seq_pkg::chan_t r;
		r = c;
		if (!keep_addr) begin
			r.cur_addr = m.step_down ? c.cur_addr - 16'h0001 : c.cur_addr + 16'h0001;
		end
		r.cur_cnt = c.cur_cnt - 16'h0001;
		return r;
	endfunction

	// Close a service that ended by end of service
	function automatic st_t close_service(st_t v, logic [1:0] c);
		st_t r;
		r = v;
		if (v.mode[c].auto_reload) begin
			r.chan[c].cur_addr = v.chan[c].base_addr;
			r.chan[c].cur_cnt  = v.chan[c].base_cnt;
		end else begin
			r.mask[c]    = 1'b1;
			r.tc_stat[c] = 1'b1;
		end
		r.sw_req[c] = 1'b0;
		return r;
	endfunction

	always_comb begin
		logic tc;
		logic eos;
		logic [1:0] c;
		tc = 1'b0;
		eos = 1'b0;
		c = 2'h0;
		next_st = st;
		next_st.s1       = {channel_request, hold_grant, ready, cs_n, io_read_strobe_n_in,
			io_write_strobe_n_in, register_select_lines, data_in, end_of_service_n_in};
		next_st.s2       = st.s1;
		next_st.iow_prev = st.s2.iow_n;
		next_st.ior_prev = st.s2.ior_n;
		next_st.tc_out   = 1'b0;
		c = st.s2.sel[2:1];

		if (wr_edge) begin
			if (!st.s2.sel[3]) begin
				if (st.s2.sel[0]) begin
					if (st.ptr) begin
						next_st.chan[c].cur_cnt[15:8]  = st.s2.data;
						next_st.chan[c].base_cnt[15:8] = st.s2.data;
					end else begin
						next_st.chan[c].cur_cnt[7:0]  = st.s2.data;
						next_st.chan[c].base_cnt[7:0] = st.s2.data;
					end
				end else if (st.ptr) begin
					next_st.chan[c].cur_addr[15:8]  = st.s2.data;
					next_st.chan[c].base_addr[15:8] = st.s2.data;
				end else begin
					next_st.chan[c].cur_addr[7:0]  = st.s2.data;
					next_st.chan[c].base_addr[7:0] = st.s2.data;
				end
				next_st.ptr = !st.ptr;
			end else begin
				case (st.s2.sel)
					dma_seq_pkg::REG_CMD: next_st.command = st.s2.data;
					dma_seq_pkg::REG_REQ:
						next_st.sw_req[st.s2.data[1:0]] = st.s2.data[dma_seq_pkg::SET_BIT];
					dma_seq_pkg::REG_MASK_ONE:
						next_st.mask[st.s2.data[1:0]] = st.s2.data[dma_seq_pkg::SET_BIT];
					dma_seq_pkg::REG_MODE:
						next_st.mode[st.s2.data[1:0]] = dma_seq_pkg::mode_t'(st.s2.data[7:2]);
					dma_seq_pkg::REG_CLR_PTR: next_st.ptr = 1'b0;
					dma_seq_pkg::REG_MCLR: begin
						next_st.command = 8'h00;
						next_st.sw_req  = 4'h0;
						next_st.tc_stat = 4'h0;
						next_st.mask    = dma_seq_pkg::MASK_RESET;
						next_st.ptr     = 1'b0;
						next_st.temp    = 8'h00;
						next_st.hold    = 1'b0;
						next_st.fsm     = dma_seq_pkg::ST_IDLE;
					end
					dma_seq_pkg::REG_CLR_MASK: next_st.mask = 4'h0;
					dma_seq_pkg::REG_MASK_ALL: next_st.mask = st.s2.data[3:0];
					default: next_st.command = st.command;
				endcase
			end
		end

		if (rd_edge) begin
			if (!st.s2.sel[3]) begin
				if (st.s2.sel[0]) begin
					next_st.dout = st.ptr ? st.chan[c].cur_cnt[15:8] : st.chan[c].cur_cnt[7:0];
				end else begin
					next_st.dout = st.ptr ? st.chan[c].cur_addr[15:8] : st.chan[c].cur_addr[7:0];
				end
				next_st.ptr = !st.ptr;
			end else if (st.s2.sel == dma_seq_pkg::REG_STATUS) begin
				next_st.dout    = {st.s2.req | st.sw_req, st.tc_stat};
				next_st.tc_stat = 4'h0;
			end else if (st.s2.sel == dma_seq_pkg::REG_TEMP) begin
				next_st.dout = st.temp;
			end else begin
				next_st.dout = 8'h00;
			end
		end

		case (st.fsm)
			dma_seq_pkg::ST_IDLE: begin
				if (pick_any && !st.s2.grant_in && !wr_edge) begin
					next_st.hold = 1'b1;
					next_st.fsm  = dma_seq_pkg::ST_HOLD;
				end
			end
			dma_seq_pkg::ST_HOLD: begin
				if (!pick_any) begin
					next_st.hold = 1'b0;
					next_st.fsm  = dma_seq_pkg::ST_IDLE;
				end else if (st.s2.grant_in) begin
					next_st.ch      = pick_index;
					next_st.m2m     = st.command[dma_seq_pkg::CMD_M2M] && pick_grant[0] &&
						st.sw_req[0];
					next_st.cascade = (st.mode[pick_index].service == dma_seq_pkg::MD_CASCADE);
					next_st.fsm     = next_st.m2m ? dma_seq_pkg::ST_M11 : dma_seq_pkg::ST_S1;
				end
			end
			dma_seq_pkg::ST_S1: begin
				if (!st.cascade) begin
					next_st.fsm = dma_seq_pkg::ST_S2;
				end else if (!st.s2.req[st.ch]) begin
					next_st.hold = 1'b0;
					next_st.fsm  = dma_seq_pkg::ST_IDLE;
				end
			end
			dma_seq_pkg::ST_S2: next_st.fsm = dma_seq_pkg::ST_S3;
			dma_seq_pkg::ST_S3: begin
				if (!st.s2.ready && xf != dma_seq_pkg::XF_VERIFY) begin
					next_st.fsm = dma_seq_pkg::ST_WAIT;
				end else begin
					next_st.fsm = dma_seq_pkg::ST_S4;
				end
			end
			dma_seq_pkg::ST_WAIT: begin
				if (st.s2.ready) begin
					next_st.fsm = dma_seq_pkg::ST_S4;
				end
			end
			dma_seq_pkg::ST_S4: begin
				tc  = (st.chan[st.ch].cur_cnt == dma_seq_pkg::CNT_ZERO);
				eos = tc || !st.s2.eos_n;
				next_st.chan[st.ch] = advance(st.chan[st.ch], st.mode[st.ch], 1'b0);
				next_st.tc_out = tc;
				next_st.fsm    = dma_seq_pkg::ST_IDLE;
				next_st.hold   = 1'b0;
				if (st.mode[st.ch].service == dma_seq_pkg::MD_BLOCK && !eos) begin
					next_st.fsm  = dma_seq_pkg::ST_S2;
					next_st.hold = 1'b1;
				end
				if (st.mode[st.ch].service == dma_seq_pkg::MD_DEMAND && !eos &&
					st.s2.req[st.ch]) begin
					next_st.fsm  = dma_seq_pkg::ST_S2;
					next_st.hold = 1'b1;
				end
				if (eos) begin
					next_st = close_service(next_st, st.ch);
				end
			end
			dma_seq_pkg::ST_M11: next_st.fsm = dma_seq_pkg::ST_M12;
			dma_seq_pkg::ST_M12: next_st.fsm = dma_seq_pkg::ST_M13;
			dma_seq_pkg::ST_M13: next_st.fsm = dma_seq_pkg::ST_M14;
			dma_seq_pkg::ST_M14: begin
				if (buf_in_ready) begin
					next_st.temp    = st.s2.data;
					next_st.chan[0] = advance(st.chan[0], st.mode[0],
						st.command[dma_seq_pkg::CMD_HOLD0]);
					next_st.fsm     = dma_seq_pkg::ST_M21;
				end
			end
			dma_seq_pkg::ST_M21: next_st.fsm = dma_seq_pkg::ST_M22;
			dma_seq_pkg::ST_M22: next_st.fsm = dma_seq_pkg::ST_M23;
			dma_seq_pkg::ST_M23: next_st.fsm = dma_seq_pkg::ST_M24;
			dma_seq_pkg::ST_M24: begin
				tc  = (st.chan[1].cur_cnt == dma_seq_pkg::CNT_ZERO);
				eos = tc || !st.s2.eos_n;
				next_st.chan[1] = advance(st.chan[1], st.mode[1], 1'b0);
				next_st.tc_out  = tc;
				next_st.fsm     = dma_seq_pkg::ST_M11;
				if (eos) begin
					next_st      = close_service(next_st, 2'h1);
					next_st      = close_service(next_st, 2'h0);
					next_st.m2m  = 1'b0;
					next_st.hold = 1'b0;
					next_st.fsm  = dma_seq_pkg::ST_IDLE;
				end
			end
			default: next_st.fsm = dma_seq_pkg::ST_IDLE;
		endcase

		if (next_st.fsm inside {dma_seq_pkg::ST_M21, dma_seq_pkg::ST_M22,
			dma_seq_pkg::ST_M23, dma_seq_pkg::ST_M24}) begin
			next_st.dout    = buf_out_data;
			next_st.dout_oe = 1'b1;
		end else begin
			next_st.dout_oe = prog && !st.s2.ior_n;
		end
	end

	always_ff @(posedge mclk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			st          <= '0;
			st.s1.cs_n  <= 1'b1;
			st.s1.ior_n <= 1'b1;
			st.s1.iow_n <= 1'b1;
			st.s1.eos_n <= 1'b1;
			st.s2.cs_n  <= 1'b1;
			st.s2.ior_n <= 1'b1;
			st.s2.iow_n <= 1'b1;
			st.s2.eos_n <= 1'b1;
			st.fsm      <= dma_seq_pkg::ST_IDLE;
			st.mask     <= dma_seq_pkg::MASK_RESET;
		end else begin
			st <= next_st;
		end
	end

	assign xf      = st.mode[st.ch].xfer;
	assign working = st.fsm inside {dma_seq_pkg::ST_S2, dma_seq_pkg::ST_S3,
		dma_seq_pkg::ST_WAIT, dma_seq_pkg::ST_S4};
	assign active  = !(st.fsm inside {dma_seq_pkg::ST_IDLE, dma_seq_pkg::ST_HOLD}) && !st.cascade;
	assign addr_ch = (st.fsm inside {dma_seq_pkg::ST_M21, dma_seq_pkg::ST_M22,
		dma_seq_pkg::ST_M23, dma_seq_pkg::ST_M24}) ? 2'h1 : st.ch;

	// Outside memory-to-memory, strobes pair so data passes straight between I/O and memory
	assign io_read_strobe_n_out  = !(xf == dma_seq_pkg::XF_WRITE && working && !st.m2m);
	assign io_write_strobe_n_out = !(xf == dma_seq_pkg::XF_READ && !st.m2m &&
		(working && st.fsm != dma_seq_pkg::ST_S2));
	assign memory_read_strobe_n  = !((st.fsm inside {dma_seq_pkg::ST_M12, dma_seq_pkg::ST_M13,
		dma_seq_pkg::ST_M14}) || (xf == dma_seq_pkg::XF_READ && working && !st.m2m));
	assign memory_write_strobe_n = !((st.fsm inside {dma_seq_pkg::ST_M22, dma_seq_pkg::ST_M23,
		dma_seq_pkg::ST_M24}) || (xf == dma_seq_pkg::XF_WRITE && !st.m2m &&
		working && st.fsm != dma_seq_pkg::ST_S2));
	assign io_read_strobe_oe     = active;
	assign io_write_strobe_oe    = active;
	assign address_oe            = active;
	assign address_out           = st.chan[addr_ch].cur_addr;
	assign channel_grant         = (st.fsm inside {dma_seq_pkg::ST_IDLE, dma_seq_pkg::ST_HOLD}
		|| st.m2m) ? 4'h0 : (4'h1 << st.ch);
	assign bus_hold_request      = st.hold;
	assign terminal_count        = st.tc_out;
	assign end_of_service_n_out  = 1'b0;
	assign end_of_service_oe     = st.tc_out;
	assign data_out              = st.dout;
	assign data_oe               = st.dout_oe;
endmodule // dma_sequencer

// File: rtl/dma_seq_pkg.sv
// Constants, types and carriers shared by the four-channel transfer sequencer
package dma_seq_pkg;
	localparam int NCH = 4;
	localparam logic [3:0] REG_CMD      = 4'h8;
	localparam logic [3:0] REG_STATUS   = 4'h8;
	localparam logic [3:0] REG_REQ      = 4'h9;
	localparam logic [3:0] REG_MASK_ONE = 4'ha;
	localparam logic [3:0] REG_MODE     = 4'hb;
	localparam logic [3:0] REG_CLR_PTR  = 4'hc;
	localparam logic [3:0] REG_MCLR     = 4'hd;
	localparam logic [3:0] REG_TEMP     = 4'hd;
	localparam logic [3:0] REG_CLR_MASK = 4'he;
	localparam logic [3:0] REG_MASK_ALL = 4'hf;
	localparam int CMD_M2M      = 0;
	localparam int CMD_HOLD0    = 1;
	localparam int CMD_DISABLE  = 2;
	localparam int SET_BIT      = 2;
	localparam logic [3:0]  MASK_RESET = 4'hf;
	localparam logic [15:0] CNT_ZERO   = 16'h0000;
	localparam logic [1:0] XF_VERIFY  = 2'h0;
	localparam logic [1:0] XF_WRITE   = 2'h1;
	localparam logic [1:0] XF_READ    = 2'h2;
	localparam logic [1:0] MD_DEMAND  = 2'h0;
	localparam logic [1:0] MD_SINGLE  = 2'h1;
	localparam logic [1:0] MD_BLOCK   = 2'h2;
	localparam logic [1:0] MD_CASCADE = 2'h3;

	typedef enum logic [14:0] {
		ST_IDLE = 15'h0001,
		ST_HOLD = 15'h0002,
		ST_S1   = 15'h0004,
		ST_S2   = 15'h0008,
		ST_S3   = 15'h0010,
		ST_S4   = 15'h0020,
		ST_WAIT = 15'h0040,
		ST_M11  = 15'h0080,
		ST_M12  = 15'h0100,
		ST_M13  = 15'h0200,
		ST_M14  = 15'h0400,
		ST_M21  = 15'h0800,
		ST_M22  = 15'h1000,
		ST_M23  = 15'h2000,
		ST_M24  = 15'h4000
	} fsm_t;

	typedef struct packed {
		logic [1:0] service;
		logic       step_down;
		logic       auto_reload;
		logic [1:0] xfer;
	} mode_t;

	typedef struct packed {
		logic [15:0] base_addr;
		logic [15:0] base_cnt;
		logic [15:0] cur_addr;
		logic [15:0] cur_cnt;
	} chan_t;

	typedef struct packed {
		logic [3:0] req;
		logic       grant_in;
		logic       ready;
		logic       cs_n;
		logic       ior_n;
		logic       iow_n;
		logic [3:0] sel;
		logic [7:0] data;
		logic       eos_n;
	} pins_t;
endpackage

// File: rtl/fixed_priority.sv
// Fixed priority picker, lowest channel number wins
`timescale 1ns/1ns
module fixed_priority #(
	parameter int N = 4
) (
	input  wire logic [N-1:0]         req,
	output logic      [N-1:0]         grant,
	output logic      [$clog2(N)-1:0] index,
	output logic                      any
);
	logic [N:0] higher;

	assign higher[0] = 1'b0;
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_pick
			assign grant[i]    = req[i] & ~higher[i];
			assign higher[i+1] = higher[i] | req[i];
		end
	endgenerate
	assign any = higher[N];

	always_comb begin
		index = '0;
		for (int k = N - 1; k >= 0; k--) begin
			if (req[k]) begin
				index = k[$clog2(N)-1:0];
			end
		end
	end
endmodule // fixed_priority

// File: rtl/two_entry_buffer.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ns
module two_entry_buffer #(
	parameter int WIDTH = 8
) (
	input  wire logic             mclk,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	typedef struct packed {
		logic [1:0][WIDTH-1:0] slot;
		logic [1:0]            fill;
	} buf_t;

	buf_t st;
	buf_t next_st;
	logic push;
	logic pop;

	assign in_ready  = (st.fill != 2'h2);
	assign out_valid = (st.fill != 2'h0);
	assign out_data  = st.slot[0];
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always_comb begin
		next_st = st;
		if (pop) begin
			next_st.slot[0] = st.slot[1];
		end
		if (push) begin
			if (st.fill == 2'h0 || (st.fill == 2'h1 && pop)) begin
				next_st.slot[0] = in_data;
			end else begin
				next_st.slot[1] = in_data;
			end
		end
		next_st.fill = st.fill + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
endmodule // two_entry_buffer

// File: tb/dma_seq_checker.sv
// Port assertions for the transfer sequencer
`timescale 1ns/1ns
module dma_seq_checker (
	input wire logic       mclk,
	input wire logic       rst_n,
	input wire logic       hold_grant,
	input wire logic       io_read_strobe_n_out,
	input wire logic       io_read_strobe_oe,
	input wire logic       io_write_strobe_n_out,
	input wire logic       io_write_strobe_oe,
	input wire logic       end_of_service_n_out,
	input wire logic       end_of_service_oe,
	input wire logic       bus_hold_request,
	input wire logic [3:0] channel_grant,
	input wire logic       memory_read_strobe_n,
	input wire logic       memory_write_strobe_n,
	input wire logic       terminal_count
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);
	AST_GRANT_HOLD: assert property (|channel_grant |-> bus_hold_request)
		else $error("grant without hold request");
	AST_ONE_GRANT: assert property ($onehot0(channel_grant))
		else $error("more than one grant");
	AST_WRITE_PAIR: assert property (|channel_grant && !memory_write_strobe_n
		|-> !io_read_strobe_n_out && io_read_strobe_oe) else $error("write pair");
	AST_READ_PAIR: assert property (|channel_grant && io_write_strobe_oe
		&& !io_write_strobe_n_out |-> !memory_read_strobe_n) else $error("read pair");
	AST_HALVES: assert property (!(!memory_read_strobe_n && !memory_write_strobe_n))
		else $error("both memory strobes low");
	AST_TC_END: assert property (terminal_count
		|-> end_of_service_oe && !end_of_service_n_out)
		else $error("terminal count without end signal");
	AST_TC_PULSE: assert property (terminal_count |=> !terminal_count)
		else $error("terminal count too long");
	AST_AFTER_GRANT: assert property ($rose(|channel_grant) |-> $past(hold_grant, 3))
		else $error("grant before hold grant");
	AST_STROBE_LEN: assert property ($fell(memory_write_strobe_n) |=> !memory_write_strobe_n)
		else $error("write strobe too short");
endmodule // dma_seq_checker
bind dma_sequencer dma_seq_checker chk (.mclk(mclk), .rst_n(rst_n), .hold_grant(hold_grant),
	.io_read_strobe_n_out(io_read_strobe_n_out), .io_read_strobe_oe(io_read_strobe_oe),
	.io_write_strobe_n_out(io_write_strobe_n_out), .io_write_strobe_oe(io_write_strobe_oe),
	.end_of_service_n_out(end_of_service_n_out), .end_of_service_oe(end_of_service_oe),
	.bus_hold_request(bus_hold_request), .channel_grant(channel_grant),
	.memory_read_strobe_n(memory_read_strobe_n), .memory_write_strobe_n(memory_write_strobe_n),
	.terminal_count(terminal_count));

// File: tb/dma_partner.sv
// Processor, peripheral and memory stand-in
`timescale 1ns/1ns
module dma_partner (
	input  wire logic       mclk,
	input  wire logic       rst_n,
	input  wire logic       bus_hold_request,
	input  wire logic [3:0] want,
	input  wire logic       slow,
	output logic      [3:0] channel_request,
	output logic            hold_grant,
	output logic            ready
);
	logic [1:0] hold_dly;
	logic [1:0] tick;
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			hold_dly        <= 2'h0;
			tick            <= 2'h0;
			channel_request <= 4'h0;
		end else begin
			hold_dly        <= {hold_dly[0], bus_hold_request};
			tick            <= tick + 2'h1;
			channel_request <= want;
		end
	end
	assign hold_grant = hold_dly[1] & bus_hold_request;
	assign ready      = !slow | tick[1];
endmodule // dma_partner

// File: tb/tb_top.sv
// Self-checking bench for the transfer sequencer
`timescale 1ns/1ns
module tb_top;
	logic        mclk = 1'b0, rst_n = 1'b0, slow = 1'b0, cs_n = 1'b1, ior_n = 1'b1;
	logic        iow_n = 1'b1, eos_n = 1'b1, pmw = 1'b1, piow = 1'b1, phold = 1'b0;
	logic [3:0]  want = 4'h0, sel = 4'h0, req, grant;
	logic [7:0]  din = 8'h00, dout, m2m_data, rnd = 8'h14;
	logic        hg, rdy, hold, tc, mr_n, mw_n, d_oe, ao, eo, e_oe;
	logic        ro, r_oe, wo, w_oe;
	logic [15:0] addr, a;
	logic [19:0] notes[$];
	int          num_errors = 0, samples_checked = 0, cycles = 0;
	int          tc_seen = 0, strobes = 0, rises = 0, bad;
	dma_partner pm (.mclk(mclk), .rst_n(rst_n), .bus_hold_request(hold), .want(want),
		.slow(slow), .channel_request(req), .hold_grant(hg), .ready(rdy));
	dma_sequencer dut (.mclk(mclk), .rst_n(rst_n), .channel_request(req), .hold_grant(hg),
		.ready(rdy), .cs_n(cs_n), .register_select_lines(sel),
		.io_read_strobe_n_in(r_oe ? ro : ior_n), .io_read_strobe_n_out(ro),
		.io_read_strobe_oe(r_oe), .io_write_strobe_n_in(w_oe ? wo : iow_n),
		.io_write_strobe_n_out(wo), .io_write_strobe_oe(w_oe), .data_in(d_oe ? dout : din),
		.data_out(dout), .data_oe(d_oe), .end_of_service_n_in(e_oe ? eo : eos_n),
		.end_of_service_n_out(eo), .end_of_service_oe(e_oe), .bus_hold_request(hold),
		.channel_grant(grant), .address_out(addr), .address_oe(ao),
		.memory_read_strobe_n(mr_n), .memory_write_strobe_n(mw_n), .terminal_count(tc));
	always #4 mclk = ~mclk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [7:0] md(input logic [1:0] svc, input logic dn, input logic [1:0] xf);
		return {svc, dn, 1'b0, xf, 2'h0};
	endfunction
	task automatic end_sim;
		$display("Checks %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check_note(input logic [19:0] seen);
		logic [19:0] exp;
		exp = 20'hfffff;
		if (notes.size() != 0) exp = notes.pop_front();
		samples_checked++;
		if (exp !== seen) begin
			num_errors++;
			$display("Error transfer: expected %h seen %h", exp, seen);
		end
	endtask
	task automatic check_cnt(input string n, input int e, input int s);
		samples_checked++;
		if (e != s) begin
			num_errors++;
			$display("Error %s: expected %0d seen %0d", n, e, s);
		end
	endtask
	task automatic check8(input string n, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (e !== s) begin
			num_errors++;
			$display("Error %s: expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] s, input logic [7:0] d);
		@(posedge mclk);
		#1 cs_n = 1'b0;
		sel = s;
		din = d;
		iow_n = 1'b0;
		repeat (4) @(posedge mclk);
		#1 iow_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1 cs_n = 1'b1;
	endtask
	task automatic rd(input logic [3:0] s, input logic [7:0] e, input string n);
		@(posedge mclk);
		#1 cs_n = 1'b0;
		sel = s;
		ior_n = 1'b0;
		repeat (4) @(posedge mclk);
		check8(n, e, dout);
		check8("read enable", 8'h01, {7'h00, d_oe});
		#1 ior_n = 1'b1;
		repeat (4) @(posedge mclk);
		#1 cs_n = 1'b1;
	endtask
	task automatic prog(input logic [1:0] c, input logic [15:0] ad, input logic [15:0] cn,
		input logic [7:0] m);
		wr({1'b0, c, 1'b0}, ad[7:0]);
		wr({1'b0, c, 1'b0}, ad[15:8]);
		wr({1'b0, c, 1'b1}, cn[7:0]);
		wr({1'b0, c, 1'b1}, cn[15:8]);
		wr(4'hb, m | {6'h00, c});
	endtask
	task automatic run(input logic [3:0] w, input int ns, input int nt, input string name);
		tc_seen = 0;
		strobes = 0;
		rises = 0;
		want = w;
		for (int i = 0; i < 900 && (notes.size() != 0 || hold !== 1'b0 || i < 30); i++)
			@(posedge mclk);
		#1 want = 4'h0;
		check_cnt("left", 0, notes.size());
		check_cnt("strobes", ns, strobes);
		if (nt >= 0) check_cnt("tc", nt, tc_seen);
		$display("Test %s done", name);
	endtask
	always @(posedge mclk) begin
		pmw <= mw_n;
		piow <= w_oe ? wo : 1'b1;
		phold <= hold;
		if (tc === 1'b1) tc_seen++;
		if (hold === 1'b1 && phold === 1'b0) rises++;
		if ((pmw === 1'b1 && mw_n === 1'b0) || (piow === 1'b1 && w_oe && wo === 1'b0)) begin
			strobes++;
			check_note({grant, addr});
			check8("address enable", 8'h01, {7'h00, ao});
		end
		if (grant === 4'h0 && mw_n === 1'b0 && pmw === 1'b1) check8("m2m data", m2m_data, dout);
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 40000) begin
			num_errors++;
			end_sim;
		end
	end
	initial begin
		repeat (16) @(posedge mclk);
		#1 rst_n = 1'b1;
		repeat (5) @(posedge mclk);
		a = {8'h40, rnd};
		wr(4'h0, 8'h55);
		wr(4'hc, 8'h00);
		prog(2'h2, a, 16'h0001, md(dma_seq_pkg::MD_SINGLE, 1'b0, dma_seq_pkg::XF_WRITE));
		wr(4'he, 8'h00);
		notes.push_back({4'h4, a});
		notes.push_back({4'h4, a + 16'h0001});
		run(4'h4, 2, 1, "single");
		check_cnt("hold rises", 2, rises);
		rd(4'h8, 8'h04, "status");
		rnd = lfsr(rnd);
		a = {8'h80, rnd};
		slow = 1'b1;
		prog(2'h1, a, 16'h0002, md(dma_seq_pkg::MD_BLOCK, 1'b1, dma_seq_pkg::XF_READ));
		wr(4'he, 8'h00);
		for (int k = 0; k < 3; k++) notes.push_back({4'h2, a - 16'(k)});
		run(4'h2, 3, 1, "block read slow");
		slow = 1'b0;
		prog(2'h0, 16'h0100, 16'h0000, md(dma_seq_pkg::MD_BLOCK, 1'b0, dma_seq_pkg::XF_WRITE));
		prog(2'h2, 16'h0200, 16'h0000, md(dma_seq_pkg::MD_BLOCK, 1'b0, dma_seq_pkg::XF_VERIFY));
		prog(2'h3, 16'h0300, 16'h0000, md(dma_seq_pkg::MD_BLOCK, 1'b0, dma_seq_pkg::XF_WRITE));
		wr(4'he, 8'h00);
		notes.push_back({4'h1, 16'h0100});
		notes.push_back({4'h8, 16'h0300});
		run(4'hd, 2, 3, "priority verify");
		rnd = lfsr(rnd);
		a = {8'hc0, rnd};
		prog(2'h0, 16'h1000, 16'h0000, md(dma_seq_pkg::MD_BLOCK, 1'b0, dma_seq_pkg::XF_READ));
		prog(2'h1, a, 16'h0000, md(dma_seq_pkg::MD_BLOCK, 1'b0, dma_seq_pkg::XF_WRITE));
		wr(4'h8, 8'h01);
		wr(4'he, 8'h00);
		wr(4'h9, 8'h04);
		m2m_data = lfsr(rnd);
		din = m2m_data;
		notes.push_back({4'h0, a});
		run(4'h0, 1, 1, "memory to memory");
		rd(4'hd, m2m_data, "temp");
		wr(4'he, 8'h00);
		wr(4'h0, 8'haa);
		wr(4'hd, 8'hff);
		want = 4'h1;
		bad = 0;
		repeat (40) @(posedge mclk) if (hold !== 1'b0) bad++;
		check_cnt("masked hold", 0, bad);
		prog(2'h0, 16'h2345, 16'h0000, md(dma_seq_pkg::MD_SINGLE, 1'b0, dma_seq_pkg::XF_WRITE));
		wr(4'he, 8'h00);
		notes.push_back({4'h1, 16'h2345});
		run(4'h1, 1, 1, "master clear");
		prog(2'h3, 16'h0500, 16'h0003, md(dma_seq_pkg::MD_DEMAND, 1'b0, dma_seq_pkg::XF_WRITE));
		wr(4'he, 8'h00);
		for (int k = 0; k < 4; k++) notes.push_back({4'h8, 16'h0500 + 16'(k)});
		strobes = 0;
		want = 4'h8;
		wait (strobes == 1);
		#1 want = 4'h0;
		repeat (20) @(posedge mclk);
		check_cnt("demand pause", 2, notes.size());
		run(4'h8, 2, 1, "demand");
		check_cnt("demand hold rises", 1, rises);
		prog(2'h2, 16'h0600, 16'h0000,
			md(dma_seq_pkg::MD_BLOCK, 1'b0, dma_seq_pkg::XF_WRITE) | 8'h10);
		repeat (2) begin
			notes.push_back({4'h4, 16'h0600});
			wr(4'h9, 8'h06);
			run(4'h0, 1, 1, "reload");
		end
		rd(4'h8, 8'h09, "status");
		end_sim;
	end
endmodule // tb_top
